// ==== rtl/ovr_format.v ====
// Purpose: Over-range flagging, clamp codes and output number format
// Assumes: Sample and overload inputs synchronous to clock
// Notes:   One sample per enabled clock; two-cycle bus latency
// Function
// - Shared pin: overload flag, or readout
// - Overload either side raises flag
// - Flag follows overload every sample
// - Positive overload: 7FFh offset, 3FFh twos
// - Negative overload: 000h offset, 400h twos
// - Format from register bit or strap
// - Flag is single-ended whatever interface
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
`include "ovr_format_defs.vh"

module ovr_format #(
  parameter DATA_W = 11
) (
  // Clock, reset, enable
  input  wire              clock,
  input  wire              sys_rst,
  input  wire              clk_en,
  // Converter core
  input  wire [DATA_W-1:0] sample_in,
  input  wire              over_pos,
  input  wire              over_neg,
  // Straps and interface select
  input  wire              format_strap_pin,
  input  wire              lvds_select,
  // Sample outputs
  output reg  [DATA_W-1:0] data_out,
  output reg               overrange_or_readout_pin,
  output reg               overrange_flag,
  // Avalon-MM slave
  input  wire [3:0]        avs_address,
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  input  wire [3:0]        avs_byteenable,
  output reg  [31:0]       avs_readdata,
  output reg               avs_waitrequest,
  // Interrupt
  output reg               irq
);

  // ============================================================
  // Format conversion
  // Twos complement from offset binary
  function [DATA_W-1:0] to_fmt;
    input [DATA_W-1:0] code;
    input              twos;
    begin
      to_fmt = twos ? {~code[DATA_W-1], code[DATA_W-2:0]} : code;
    end
  endfunction

  reg  [2:0]           ctrl;
  reg  [`EV_WIDTH-1:0] status;
  reg  [`EV_WIDTH-1:0] mask;
  reg  [31:0]          readout_word;
  reg                  ack;
  reg                  load;
  wire                 serial_bit;
  wire                 ro_busy;

  // Strap wins unless software overrides
  wire twos = ctrl[`CTRL_FMT_OVERRIDE] ? ctrl[`CTRL_FORMAT]
                                       : format_strap_pin;
  wire over_any = over_pos | over_neg;

  // ============================================================
  // Sample path
  reg [DATA_W-1:0] next_data;
  always @* begin
    if (over_pos)
      next_data = to_fmt(`CODE_POS_OB, twos);
    else if (over_neg)
      next_data = to_fmt(`CODE_NEG_OB, twos);
    else
      next_data = to_fmt(sample_in, twos);
  end

  // Flag pin is driven the same for either data interface
  wire unused_if = lvds_select;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      data_out                 <= {DATA_W{1'b0}};
      overrange_flag           <= 1'b0;
      overrange_or_readout_pin <= 1'b0;
    end else if (clk_en) begin
      data_out       <= next_data;
      overrange_flag <= over_any;
      overrange_or_readout_pin <= ctrl[`CTRL_READOUT] ? serial_bit
                                                      : over_any;
    end
  end

  // ============================================================
  // Register bus
  wire req     = avs_read | avs_write;
  wire hit_sts = avs_read & ~ack & (avs_address == `REG_STATUS);
  reg  [31:0] next_rd;
  always @* begin
    case (avs_address)
      `REG_CTRL:    next_rd = {29'h0000_0000, ctrl};
      `REG_STATUS:  next_rd = {30'h0000_0000, status};
      `REG_MASK:    next_rd = {30'h0000_0000, mask};
      `REG_READOUT: next_rd = {31'h0000_0000, ro_busy};
      default:      next_rd = 32'h0000_0000;
    endcase
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl            <= `CTRL_RESET;
      mask            <= {`EV_WIDTH{1'b0}};
      status          <= {`EV_WIDTH{1'b0}};
      readout_word    <= 32'h0000_0000;
      ack             <= 1'b0;
      load            <= 1'b0;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      irq             <= 1'b0;
    end else if (clk_en) begin
      load <= 1'b0;
      // Answer one cycle after request seen, then drop
      ack             <= req & ~ack;
      avs_waitrequest <= ~(req & ~ack);
      if (req & ~ack & avs_read)
        avs_readdata <= next_rd;
      if (req & ~ack & avs_write & avs_byteenable[0]) begin
        case (avs_address)
          `REG_CTRL: ctrl <= avs_writedata[2:0];
          `REG_MASK: mask <= avs_writedata[`EV_WIDTH-1:0];
          `REG_READOUT: begin
            readout_word <= avs_writedata;
            load         <= 1'b1;
          end
          default: ;
        endcase
      end
      // Set wins over clear-on-read
      status <= (hit_sts ? {`EV_WIDTH{1'b0}} : status)
              | {over_neg, over_pos};
      irq <= |(status & mask);
    end
  end

  readout_shifter u_shift (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .load       (load),
    .word       (readout_word),
    .serial_bit (serial_bit),
    .busy       (ro_busy)
  );

endmodule // ovr_format

// ==== rtl/ovr_format_defs.vh ====
// Purpose: Shared constants for the over-range and output format block
// Assumes: 11-bit sample bus, 32-bit Avalon-MM register port
// Notes:   Byte offsets are word aligned
`ifndef OVR_FORMAT_DEFS_VH
`define OVR_FORMAT_DEFS_VH

// ============================================================
// Register map (byte addresses)
`define REG_CTRL      4'h0
`define REG_STATUS    4'h4
`define REG_MASK      4'h8
`define REG_READOUT   4'hC

// ============================================================
// Control fields
`define CTRL_READOUT      0
`define CTRL_FORMAT       1
`define CTRL_FMT_OVERRIDE 2
`define CTRL_RESET        3'b000

// ============================================================
// Status and mask fields
`define EV_POS_OVR 0
`define EV_NEG_OVR 1
`define EV_WIDTH   2

// ============================================================
// Clamp codes, offset binary
`define CODE_POS_OB 11'h7FF
`define CODE_NEG_OB 11'h000

// ============================================================
// Readout shifter
`define READOUT_LAST 5'h1F

`endif

// ==== rtl/readout_shifter.v ====
// Purpose: Serialises a 32-bit word onto the shared pin, MSB first
// Assumes: One bit per enabled clock
// Notes:   Restarts on load; idles low when done
`timescale 1ns/10ps
`include "ovr_format_defs.vh"

module readout_shifter (
  // Clock and reset
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        clk_en,
  // Control
  input  wire        load,
  input  wire [31:0] word,
  // Serial out
  output reg         serial_bit,
  output reg         busy
);

  reg [31:0] shift;
  reg [4:0]  count;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shift      <= 32'h0000_0000;
      count      <= 5'h00;
      busy       <= 1'b0;
      serial_bit <= 1'b0;
    end else if (clk_en) begin
      if (load) begin
        shift      <= {word[30:0], 1'b0};
        serial_bit <= word[31];
        count      <= 5'h00;
        busy       <= 1'b1;
      end else if (busy) begin
        serial_bit <= shift[31];
        shift      <= {shift[30:0], 1'b0};
        count      <= count + 5'h01;
        if (count == `READOUT_LAST - 5'h01)
          busy <= 1'b0;
      end else begin
        serial_bit <= 1'b0;
      end
    end
  end

endmodule // readout_shifter

// ==== test/adc_overrange_and_output_format_tb_top.sv ====
// Purpose: Self-checking bench for the over-range block
// Assumes: clk_en and byte enables held high
// Notes:   Readout word is gathered by the capture model
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module adc_overrange_and_output_format_tb_top;
  logic        clock = 0, sys_rst = 1, clk_en = 1, over_pos = 0, over_neg = 0;
  logic        format_strap_pin = 0, lvds_select = 0, avs_read = 0;
  logic        avs_write = 0, arm = 0;
  logic [10:0] sample_in = 11'h000;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0000_0000, rdat, word;
  wire  [10:0] data_out;
  wire  [31:0] avs_readdata;
  wire         overrange_or_readout_pin, overrange_flag, avs_waitrequest, irq;
  int          num_errors = 0, total_checks = 0, cyc = 0;
  always #20 clock = ~clock;
  ovr_format dut (.*);
  capture_model cap (.clock(clock), .arm(arm), .pin(overrange_or_readout_pin),
                     .word(word));
  task results;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hold the request until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin @(posedge clock); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    rdat = avs_readdata;
    if (n >= 50) num_errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task smp(input logic f, p, n, input logic [10:0] s, e);
    @(posedge clock);
    format_strap_pin <= f;
    over_pos <= p;
    over_neg <= n;
    sample_in <= s;
    @(posedge clock);
    #1;
    `CHK(data_out, e)
    `CHK(overrange_flag, p | n)
    `CHK(overrange_or_readout_pin, p | n)
  endtask
  task t_fmt;
    for (int f = 0; f < 2; f++) begin
      smp(f[0], 1, 0, 11'h123, f ? 11'h3FF : 11'h7FF);
      smp(f[0], 0, 1, 11'h123, f ? 11'h400 : 11'h000);
      smp(f[0], 0, 0, 11'h5A5, 11'h5A5 ^ {f[0], 10'h000});
    end
  endtask
  task t_ovr;
    bus(1, 4'h0, 32'h0000_0006);
    smp(0, 0, 0, 11'h123, 11'h523);
    bus(1, 4'h0, 32'h0000_0004);
    smp(1, 0, 0, 11'h523, 11'h523);
    bus(1, 4'h0, 32'h0000_0000);
  endtask
  task t_irq;
    lvds_select <= 1'b1;
    bus(0, 4'h4, 0);
    bus(1, 4'h8, 32'h0000_0001);
    smp(0, 0, 1, 0, 0);
    smp(0, 0, 0, 0, 0);
    `CHK(irq, 1'b0)
    smp(0, 1, 0, 0, 11'h7FF);
    smp(0, 0, 0, 0, 0);
    `CHK(irq, 1'b1)
    bus(0, 4'h4, 0);
    `CHK(rdat, 32'h0000_0003)
    bus(0, 4'h4, 0);
    `CHK(rdat, 32'h0000_0000)
    `CHK(irq, 1'b0)
    bus(0, 4'h2, 0);
    `CHK(rdat, 32'h0000_0000)
  endtask
  task t_rdo;
    bus(1, 4'h0, 32'h0000_0001);
    arm <= 1'b1;
    bus(1, 4'hC, 32'hA5C3_0F96);
    repeat (40) @(posedge clock);
    `CHK(word, 32'hA5C3_0F96)
    bus(0, 4'hC, 0);
    `CHK(rdat[0], 1'b0)
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin num_errors++; results; end
  end
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    t_fmt;
    t_ovr;
    t_irq;
    t_rdo;
    results;
  end
endmodule // adc_overrange_and_output_format_tb_top

// ==== test/capture_model.sv ====
// Purpose: Capture logic behind the shared pin
// Assumes: First readout bit is a one
// Notes:   Gathers 32 bits once armed
`timescale 1ns/10ps
module capture_model (
  // Capture side
  input  wire         clock,
  input  wire         arm,
  input  wire         pin,
  output logic [31:0] word
);
  logic [5:0] n = 6'h00;
  always @(posedge clock) begin
    if (!arm)
      n <= 6'h00;
    else if ((n == 0 && pin) || (n != 0 && n < 32)) begin
      word <= {word[30:0], pin};
      n    <= n + 6'h01;
    end
  end
endmodule // capture_model

// ==== test/ovr_format_props.sv ====
// Purpose: Port assertions for the over-range block
// Assumes: clk_en held high
// Notes:   Readout bit mirrored from bus writes
`timescale 1ns/10ps
module ovr_format_props #(parameter DATA_W = 11) (
  // Watched ports
  input wire              clock,
  input wire              sys_rst,
  input wire              over_pos,
  input wire              over_neg,
  input wire              lvds_select,
  input wire [DATA_W-1:0] sample_in,
  input wire [DATA_W-1:0] data_out,
  input wire              overrange_flag,
  input wire              overrange_or_readout_pin,
  input wire [3:0]        avs_address,
  input wire              avs_write,
  input wire [31:0]       avs_writedata,
  input wire              avs_waitrequest
);
  // ========
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire ov = over_pos | over_neg;
  reg  rd;
  always @(posedge clock or posedge sys_rst)
    if (sys_rst)
      rd <= 1'b0;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h0)
      rd <= avs_writedata[0];
  // ========
  flag_set_a: assert property (ov |=> overrange_flag)
    else $error("flag low");
  flag_clr_a: assert property (!ov |=> !overrange_flag)
    else $error("flag high");
  pos_code_a: assert property (over_pos |=> &data_out[9:0])
    else $error("pos code");
  neg_code_a: assert property (over_neg && !over_pos |=> ~|data_out[9:0])
    else $error("neg code");
  low_bits_a: assert property (!ov |=> data_out[9:0] == $past(sample_in[9:0]))
    else $error("low bits");
  clamp_msb_a: assert property (over_pos ##1 (over_neg && !over_pos) |=> $changed(data_out[10]))
    else $error("clamp msb");
  lvds_flag_a: assert property (lvds_select && ov |=> overrange_flag)
    else $error("lvds flag");
  pin_flag_a: assert property (!rd && !$past(rd) |-> overrange_or_readout_pin == overrange_flag)
    else $error("pin");
endmodule // ovr_format_props
bind ovr_format ovr_format_props #(.DATA_W(DATA_W)) u_props (.*);
